/* File: logic/system_reset_sequencer.v */
// System reset sequencer with AXI4-Lite register slave
//
// Register access over AXI4-Lite was decided locally.
`include "reset_seq_consts.vh"

module system_reset_sequencer #(
    parameter TW         = 16,
    parameter CYC_POWER  = `CYC_POWER,
    parameter CYC_RC     = `CYC_RC,
    parameter CYC_XTAL   = `CYC_XTAL
) (
    input  wire        I_CLOCK,
    input  wire        I_RST_N,
    input  wire        I_WDT_OVERFLOW,
    input  wire        I_LVD_RESET,
    input  wire        I_LVD_MID,
    input  wire        I_LVD_HIGH,
    input  wire        I_RESET_PIN_N,
    input  wire        I_OSC_READY,
    output reg         O_CORE_RESET,
    output reg         O_CORE_RUN,
    output reg         O_PC_CLEAR,
    output reg         O_LOW_POWER_EXIT,
    output reg         O_IRQ,
    input  wire [9:0]  I_AWADDR,
    input  wire        I_AWVALID,
    output reg         O_AWREADY,
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output reg         O_WREADY,
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    input  wire [9:0]  I_ARADDR,
    input  wire        I_ARVALID,
    output reg         O_ARREADY,
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY
);
    localparam [2:0] ST_POWER = 3'h0;
    localparam [2:0] ST_PIN   = 3'h1;
    localparam [2:0] ST_INIT  = 3'h2;
    localparam [2:0] ST_WARM  = 3'h3;
    localparam [2:0] ST_OSC   = 3'h4;
    localparam [2:0] ST_RUN   = 3'h5;

    wire         wdt;
    wire         low_voltage_detector;
    wire         pin_n;
    wire         lv_mid;
    wire         lv_high;
    wire         osc_ok;
    wire         t_done;
    reg  [2:0]   state;
    reg  [2:0]   next_state;
    reg          t_load;
    reg  [TW-1:0] t_count;
    reg  [7:0]   flag;
    reg  [7:0]   ctrl;
    reg  [3:0]   status;
    reg  [3:0]   mask;
    reg  [3:0]   ev;
    reg  [1:0]   next_cause;
    reg          cause_load;
    reg          aw_held;
    reg          w_held;
    reg  [9:0]   aw_addr;
    reg  [31:0]  w_data;
    reg  [3:0]   w_strb;
    wire         status_rd;
    reg          boot;
    wire         do_write;

    pin_sync #(.RESET_VAL(1'b0)) u_wdt (.i_clk(I_CLOCK), .i_rst_n(I_RST_N),
        .i_async(I_WDT_OVERFLOW), .o_level(wdt));
    pin_sync #(.RESET_VAL(1'b0)) u_lvd (.i_clk(I_CLOCK), .i_rst_n(I_RST_N),
        .i_async(I_LVD_RESET), .o_level(low_voltage_detector));
    // Pin starts low; a power-on never acts on it, as ST_POWER skips the pin and CTRL_RESET clears the pin enable
    pin_sync #(.RESET_VAL(1'b0)) u_pin (.i_clk(I_CLOCK), .i_rst_n(I_RST_N),
        .i_async(I_RESET_PIN_N), .o_level(pin_n));
    pin_sync #(.RESET_VAL(1'b0)) u_lvm (.i_clk(I_CLOCK), .i_rst_n(I_RST_N),
        .i_async(I_LVD_MID), .o_level(lv_mid));
    pin_sync #(.RESET_VAL(1'b0)) u_lvh (.i_clk(I_CLOCK), .i_rst_n(I_RST_N),
        .i_async(I_LVD_HIGH), .o_level(lv_high));
    pin_sync #(.RESET_VAL(1'b0)) u_osc (.i_clk(I_CLOCK), .i_rst_n(I_RST_N),
        .i_async(I_OSC_READY), .o_level(osc_ok));

    wait_timer #(.WIDTH(TW)) u_timer (.i_clk(I_CLOCK), .i_rst_n(I_RST_N),
        .i_load(t_load), .i_count(t_count), .o_done(t_done));

    // Source priority and sequence steps
    always @* begin
        next_state = state;
        t_load     = 1'b0;
        t_count    = {TW{1'b0}};
        cause_load = 1'b0;
        next_cause = `CAUSE_WDT;
        ev         = 4'h0;
        if (low_voltage_detector) begin
            next_state = ST_POWER;
            t_load     = 1'b1;
            t_count    = CYC_POWER[TW-1:0];
            cause_load = 1'b1;
            next_cause = `CAUSE_POWER;
            ev[`EV_LVD] = (state == ST_RUN);
        end else if (ctrl[`CTRL_PIN_EN] && !pin_n && state != ST_POWER) begin
            next_state = ST_PIN;
            if (state == ST_RUN) begin
                cause_load  = 1'b1;
                next_cause  = `CAUSE_PIN;
                ev[`EV_PIN] = 1'b1;
            end
        end else if (wdt && state == ST_RUN) begin
            next_state  = ST_INIT;
            cause_load  = 1'b1;
            next_cause  = `CAUSE_WDT;
            ev[`EV_WDT] = 1'b1;
        end else begin
            case (state)
                ST_POWER: begin
                    // Timer is empty after power-on, so arm the supply wait once
                    if (boot) begin
                        t_load  = 1'b1;
                        t_count = CYC_POWER[TW-1:0];
                    end else if (t_done) begin
                        next_state = ST_PIN;
                    end
                end
                ST_PIN: begin
                    if (!ctrl[`CTRL_PIN_EN] || pin_n) begin
                        next_state = ST_INIT;
                    end
                end
                ST_INIT: begin
                    next_state = ST_WARM;
                    t_load     = 1'b1;
                    t_count    = ctrl[`CTRL_XTAL] ? CYC_XTAL[TW-1:0] : CYC_RC[TW-1:0];
                end
                ST_WARM: begin
                    if (t_done) begin
                        next_state = ST_OSC;
                    end
                end
                ST_OSC: begin
                    if (osc_ok) begin
                        next_state = ST_RUN;
                    end
                end
                ST_RUN: begin
                    next_state = ST_RUN;
                end
                default: begin
                    next_state = ST_POWER;
                end
            endcase
        end
    end

    // Sequencer state and core controls
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state            <= ST_POWER;
            boot             <= 1'b1;
            O_CORE_RESET     <= 1'b1;
            O_CORE_RUN       <= 1'b0;
            O_PC_CLEAR       <= 1'b1;
            O_LOW_POWER_EXIT <= 1'b0;
        end else begin
            state <= next_state;
            boot  <= 1'b0;
            O_CORE_RESET <= (next_state != ST_RUN);
            O_CORE_RUN   <= (next_state == ST_RUN);
            O_PC_CLEAR   <= (next_state != ST_RUN);
            O_LOW_POWER_EXIT <= (next_state != ST_RUN);
        end
    end

    assign do_write = aw_held && w_held && !O_BVALID;

    // Clear at the address edge, so an event landing on that edge survives
    assign status_rd = I_ARVALID && O_ARREADY && (I_ARADDR == `ADDR_STATUS);

    // Flag register, control, mask
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            flag <= {`CAUSE_POWER, 6'h00};
            ctrl <= `CTRL_RESET;
            mask <= 4'h0;
        end else begin
            // Live voltage flags, only while running
            flag[`FLAG_LV_MID]  <= lv_mid && state == ST_RUN;
            flag[`FLAG_LV_HIGH] <= lv_high && state == ST_RUN;
            if (do_write && w_strb[0]) begin
                if (aw_addr == `ADDR_FLAG) begin
                    flag[2:0] <= w_data[2:0];
                    flag[7:6] <= w_data[7:6];
                end
                if (aw_addr == `ADDR_CTRL) begin
                    ctrl <= w_data[7:0];
                end
                if (aw_addr == `ADDR_MASK) begin
                    mask <= w_data[3:0];
                end
            end
            if (cause_load) begin
                flag[7:6] <= next_cause;
            end
            if (state == ST_INIT) begin
                flag[2:0] <= 3'h0;
            end
            if (low_voltage_detector) begin
                flag[`FLAG_LV_MID]  <= 1'b0;
                flag[`FLAG_LV_HIGH] <= 1'b0;
            end
        end
    end

    // Sticky events; set wins over read clear
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            status <= 4'h0;
            O_IRQ  <= 1'b0;
        end else begin
            status <= (status & {4{~status_rd}}) | ev |
                      {3'h0, state == ST_POWER && next_state == ST_PIN};
            O_IRQ  <= |(status & mask);
        end
    end

    // AXI4-Lite write: address and data taken in either order
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_addr   <= 10'h000;
            w_data    <= 32'h00000000;
            w_strb    <= 4'h0;
            O_AWREADY <= 1'b0;
            O_WREADY  <= 1'b0;
            O_BVALID  <= 1'b0;
            O_BRESP   <= 2'h0;
        end else begin
            O_AWREADY <= !aw_held && !O_AWREADY && !O_BVALID;
            O_WREADY  <= !w_held && !O_WREADY && !O_BVALID;
            if (I_AWVALID && O_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= I_AWADDR;
            end
            if (I_WVALID && O_WREADY) begin
                w_held <= 1'b1;
                w_data <= I_WDATA;
                w_strb <= I_WSTRB;
            end
            if (do_write) begin
                aw_held  <= 1'b0;
                w_held   <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP  <= (aw_addr == `ADDR_FLAG || aw_addr == `ADDR_CTRL ||
                             aw_addr == `ADDR_MASK || aw_addr == `ADDR_STATUS ||
                             aw_addr == `ADDR_CORE) ? 2'h0 : 2'h2;
            end else if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
            end
        end
    end

    // AXI4-Lite read; status read clears sticky bits
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_ARREADY <= 1'b0;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h00000000;
            O_RRESP   <= 2'h0;
        end else begin
            O_ARREADY <= !O_ARREADY && !O_RVALID;
            if (I_ARVALID && O_ARREADY) begin
                O_RVALID <= 1'b1;
                O_RRESP  <= 2'h0;
                case (I_ARADDR)
                    `ADDR_FLAG:   O_RDATA <= {24'h000000, flag[7:4], 1'b0, flag[2:0]};
                    `ADDR_CTRL:   O_RDATA <= {24'h000000, ctrl};
                    `ADDR_MASK:   O_RDATA <= {28'h0000000, mask};
                    `ADDR_CORE:   O_RDATA <= {29'h0, state};
                    `ADDR_STATUS: O_RDATA <= {28'h0000000, status};
                    default: begin
                        O_RDATA <= 32'h00000000;
                        O_RRESP <= 2'h2;
                    end
                endcase
            end else if (O_RVALID && I_RREADY) begin
                O_RVALID <= 1'b0;
            end
        end
    end
endmodule // system_reset_sequencer

/* File: logic/reset_seq_consts.vh */
// Constants of the system reset sequencer: offsets, fields, resets and timing
// What this block does
// - Power-on, watchdog, low-voltage, external pin cause reset
// - External pin honoured only when enabled
// - Reset halts core, inits registers, clears counter
// - Execution starts at program address zero
// - Cause in bits 7:6: 00,01,10,11 coding
// - Cause bits stay readable after reset
// - Power-on waits for stable supply first
// - Enabled pin held low keeps device reset
// - Wait oscillator warm-up before running
// - Watchdog reset skips the power-up wait
// - Watchdog reset restarts in normal mode
// - Warm-up longer for crystal than RC
// - External reset pin is active low
// - Low-voltage reset clears both voltage flags
`ifndef RESET_SEQ_CONSTS_VH
`define RESET_SEQ_CONSTS_VH

// Flag register index 0x86 is not word aligned; its byte address is four times it
`define FLAG_INDEX         8'h86
`define ADDR_FLAG          10'h218
`define ADDR_CTRL          10'h000
`define ADDR_STATUS        10'h004
`define ADDR_MASK          10'h008
`define ADDR_CORE          10'h00C

// Flag register fields
`define FLAG_CAUSE_HI      7
`define FLAG_CAUSE_LO      6
`define FLAG_LV_HIGH       5
`define FLAG_LV_MID        4
`define FLAG_WR_MASK       8'hC7

// Reset cause codes
`define CAUSE_WDT          2'h0
`define CAUSE_RSVD         2'h1
`define CAUSE_POWER        2'h2
`define CAUSE_PIN          2'h3

// Control register fields and reset value
`define CTRL_PIN_EN        0
`define CTRL_XTAL          1
`define CTRL_RESET         8'h00

// Event status bits
`define EV_POWER           0
`define EV_WDT             1
`define EV_LVD             2
`define EV_PIN             3

// Timing in nanoseconds and derived cycles at 5 ns clock
`define CLK_PERIOD_NS      5
`define T_POWER_NS         1000
`define T_RC_NS            500
`define T_XTAL_NS          20000
`define CYC_POWER          (`T_POWER_NS / `CLK_PERIOD_NS)
`define CYC_RC             (`T_RC_NS / `CLK_PERIOD_NS)
`define CYC_XTAL           (`T_XTAL_NS / `CLK_PERIOD_NS)

`endif

/* File: logic/pin_sync.v */
// Three-stage synchroniser; level changes once stages two and three agree
module pin_sync #(
    parameter RESET_VAL = 1'b0
) (
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_async,
    output reg  o_level
);
    reg s1;
    reg s2;
    reg s3;

    // Stage one only feeds stage two
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1      <= RESET_VAL;
            s2      <= RESET_VAL;
            s3      <= RESET_VAL;
            o_level <= RESET_VAL;
        end else begin
            s1 <= i_async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                o_level <= s3;
            end
        end
    end
endmodule // pin_sync

/* File: logic/wait_timer.v */
// Loadable down counter, done flag when it reaches zero
module wait_timer #(
    parameter WIDTH = 16
) (
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire             i_load,
    input  wire [WIDTH-1:0] i_count,
    output wire             o_done
);
    reg [WIDTH-1:0] count;

    // Load wins over counting
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count <= {WIDTH{1'b0}};
        end else if (i_load) begin
            count <= i_count;
        end else if (count != {WIDTH{1'b0}}) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign o_done = (count == {WIDTH{1'b0}}) && !i_load;
endmodule // wait_timer

/* File: bench/reset_seq_properties.sv */
// Port checker of the system reset sequencer
module reset_seq_chk #(
    parameter CYC_RC = 4
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic I_WDT_OVERFLOW,
    input wire logic I_LVD_RESET,
    input wire logic I_OSC_READY,
    input wire logic I_RREADY,
    input wire logic O_CORE_RESET,
    input wire logic O_CORE_RUN,
    input wire logic O_PC_CLEAR,
    input wire logic O_LOW_POWER_EXIT,
    input wire logic O_RVALID
);
    int rlen;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    // Length of the running core reset, restarts at zero
    always @(posedge I_CLOCK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rlen <= 0;
        end else begin
            rlen <= O_CORE_RESET ? rlen + 1 : 0;
        end
    end
    chk_run_inverse: assert property (O_CORE_RUN == !O_CORE_RESET)
        else $error("run not inverse of reset");
    chk_pc_cleared: assert property (O_CORE_RESET |-> O_PC_CLEAR)
        else $error("counter not cleared in reset");
    chk_normal_mode: assert property (O_LOW_POWER_EXIT |-> O_CORE_RESET)
        else $error("mode exit outside reset");
    chk_wdt_resets: assert property ($rose(I_WDT_OVERFLOW) && O_CORE_RUN |-> ##[1:10] O_CORE_RESET)
        else $error("watchdog did not reset");
    chk_lvd_resets: assert property ($rose(I_LVD_RESET) |-> ##[1:10] O_CORE_RESET)
        else $error("brown-out did not reset");
    chk_osc_first: assert property ($rose(O_CORE_RUN) |-> $past(I_OSC_READY, 3))
        else $error("run before oscillator ready");
    chk_warmup_len: assert property ($fell(O_CORE_RESET) |-> rlen >= CYC_RC)
        else $error("warm-up too short");
    chk_read_single: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
        else $error("read answer repeated");
endmodule // reset_seq_chk

bind system_reset_sequencer reset_seq_chk #(.CYC_RC(CYC_RC)) u_chk (
    .I_CLOCK, .I_RST_N, .I_WDT_OVERFLOW, .I_LVD_RESET, .I_OSC_READY, .I_RREADY,
    .O_CORE_RESET, .O_CORE_RUN, .O_PC_CLEAR, .O_LOW_POWER_EXIT, .O_RVALID);

/* File: bench/reset_env_model.sv */
// Far-side model: reset pin, voltage detector and oscillator
module reset_env_model #(
    parameter OSC_DLY = 2
) (
    input  wire logic i_clk,
    input  wire logic i_core_reset,
    input  wire logic i_pin_hold,
    input  wire logic i_brown,
    input  wire logic i_vlow,
    output logic      o_pin_n = 1'b1,
    output logic      o_lvd_reset = 1'b0,
    output logic      o_lvd_mid = 1'b0,
    output logic      o_lvd_high = 1'b0,
    output logic      o_osc_ready = 1'b1
);
    int   cnt = 0;
    logic was = 1'b0;
    always @(posedge i_clk) begin
        o_pin_n <= !i_pin_hold;
        o_lvd_reset <= i_brown;
        o_lvd_mid <= i_vlow & !i_brown;
        o_lvd_high <= i_vlow & !i_brown;
    end
    always @(posedge i_clk) begin
        was <= i_core_reset;
        cnt <= (i_core_reset && !was) ? OSC_DLY : (cnt > 0 ? cnt - 1 : 0);
        o_osc_ready <= !(i_core_reset && !was) && cnt <= 1;
    end
endmodule // reset_env_model

/* File: bench/tb.sv */
// Self-checking bench of the system reset sequencer
`include "reset_seq_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam P = 40, R = 4, X = 16;
    logic        clk, rst_n, wdt, pin_hold, brown, vlow, pin_n, low_voltage_detector, mid, high, osc;
    logic        core_rst, run, pcc, lpe, irq, lp;
    logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    int          errors = 0, tests_run = 0, rc_len, xt_len;

    system_reset_sequencer #(.CYC_POWER(P), .CYC_RC(R), .CYC_XTAL(X)) DUT (
        .I_CLOCK(clk), .I_RST_N(rst_n), .I_WDT_OVERFLOW(wdt), .I_LVD_RESET(low_voltage_detector), .I_LVD_MID(mid),
        .I_LVD_HIGH(high), .I_RESET_PIN_N(pin_n), .I_OSC_READY(osc), .O_CORE_RESET(core_rst),
        .O_CORE_RUN(run), .O_PC_CLEAR(pcc), .O_LOW_POWER_EXIT(lpe), .O_IRQ(irq), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
        .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
        .I_RREADY(rready));
    reset_env_model #(.OSC_DLY(2)) ENV (.i_clk(clk), .i_core_reset(core_rst), .i_pin_hold(pin_hold),
        .i_brown(brown), .i_vlow(vlow), .o_pin_n(pin_n), .o_lvd_reset(low_voltage_detector), .o_lvd_mid(mid),
        .o_lvd_high(high), .o_osc_ready(osc));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task chk(input [31:0] g, input [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task wr(input [9:0] a, input [31:0] v);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                w_ok = 1;
                wvalid <= 0;
            end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 0;
        r = bresp;
    endtask

    task rd(input [9:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        rready <= 0;
        d = rdata;
        r = rresp;
    endtask

    // Cycles of the next core reset; notes whether normal mode was forced
    task rst_len(output int n);
        n = 0;
        lp = 0;
        while (!core_rst) @(posedge clk);
        while (core_rst) begin
            @(posedge clk);
            n++;
            lp |= lpe;
        end
    endtask

    task t_boot;
        int n;
        rst_len(n);
        chk(n >= P + R, 1);
        chk(pcc, 0);
        chk(run, 1);
        rd(`ADDR_FLAG);
        chk(d[7:4], {`CAUSE_POWER, 2'b00});
        rd(`ADDR_CTRL);
        chk(d, `CTRL_RESET);
        rd(`ADDR_STATUS);
        chk(d[`EV_POWER], 1);
        rd(`ADDR_STATUS);
        chk(d[3:0], 0);
        rd(10'h3F0);
        chk(r, 2'h2);
        wr(10'h3F0, 0);
        chk(r, 2'h2);
        $display("boot test done");
    endtask

    task t_wdt(input logic xt, output int n);
        wr(`ADDR_CTRL, {30'h0, xt, 1'b0});
        wr(`ADDR_MASK, 0);
        chk(r, 2'h0);
        wdt <= 1;
        while (!core_rst) @(posedge clk);
        wdt <= 0;
        rst_len(n);
        chk(n < P, 1);
        chk(n >= (xt ? X : R), 1);
        chk(lp, 1);
        rd(`ADDR_FLAG);
        chk(d[7:6], `CAUSE_WDT);
        chk(irq, 0);
        wr(`ADDR_MASK, 32'h2);
        repeat (2) @(posedge clk);
        chk(irq, 1);
        rd(`ADDR_STATUS);
        chk(d[`EV_WDT], 1);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        $display("watchdog test done");
    endtask

    task t_pin;
        int n;
        wr(`ADDR_CTRL, 0);
        pin_hold <= 1;
        repeat (20) @(posedge clk);
        chk(core_rst, 0);
        pin_hold <= 0;
        repeat (8) @(posedge clk);
        wr(`ADDR_CTRL, 1);
        pin_hold <= 1;
        while (!core_rst) @(posedge clk);
        repeat (30) @(posedge clk);
        chk(core_rst, 1);
        pin_hold <= 0;
        rst_len(n);
        rd(`ADDR_FLAG);
        chk(d[7:6], `CAUSE_PIN);
        rd(`ADDR_FLAG);
        chk(d[7:6], `CAUSE_PIN);
        $display("pin test done");
    endtask

    task t_lvd;
        int n;
        vlow <= 1;
        repeat (8) @(posedge clk);
        rd(`ADDR_FLAG);
        chk(d[5:4], 2'b11);
        brown <= 1;
        while (!core_rst) @(posedge clk);
        brown <= 0;
        vlow <= 0;
        rst_len(n);
        chk(n >= P, 1);
        rd(`ADDR_FLAG);
        chk(d[7:4], {`CAUSE_POWER, 2'b00});
        $display("brown-out test done");
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles, far below the 100 us limit
    initial begin
        #100us;
        errors++;
        final_report;
    end

    // Main sequence
    initial begin
        {clk, rst_n, wdt, pin_hold, brown, vlow} = 0;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        t_boot;
        t_wdt(0, rc_len);
        t_wdt(1, xt_len);
        chk(xt_len > rc_len, 1);
        t_pin;
        t_lvd;
        final_report;
    end
endmodule // tb
